// [src/interrupt_status_enable_regs.sv]
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "irq_regs_params.svh"
module interrupt_status_enable_regs (
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   input  wire logic        CE,
   input  wire logic [9:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [3:0]  BYTEENABLE,
   input  wire logic [31:0] WRITEDATA,
   output logic [31:0]      READDATA,
   output logic             WAITREQUEST,
   input  wire logic [3:0]  BANK_SEL,
   input  wire logic        EXT_PIN_EDGE,
   input  wire logic        CLK_PIN_EDGE,
   input  wire logic        TIMER_ZERO_OVF,
   input  wire logic [7:0]  PERIPH_FLAGS,
   input  wire logic [7:0]  PERIPH_FLAGS_HI,
   input  wire logic        CORE_ACK,
   input  wire logic        RETURN_FROM_INTERRUPT,
   input  wire logic        GLOBAL_DIS_SET,
   input  wire logic        GLOBAL_DIS_CLR,
   output logic             IRQ_REQUEST,
   output logic [15:0]      VECTOR_ADDR,
   output logic             VECTOR_LOAD,
   output logic             PUSH_RETURN,
   output logic             GLOBAL_INTERRUPT_DISABLE,
   output logic [7:0]       PERIPH_REQUESTS,
   output logic             IRQ
);
   logic [7:0]              ext_meta_q;
   logic [7:0]              ext_sync_q;
   logic                    ext_pin_edge_flag;
   logic                    clock_pin_edge_flag;
   logic                    timer_zero_overflow_flag;
   logic                    peripheral_summary_flag;
   logic [3:0]              core_en_q;
   logic [7:0]              peripheral_enable_first;
   logic                    global_interrupt_disable_q;
   logic [3:0]              irq_status_q;
   logic [3:0]              irq_mask_q;
   logic [7:0]              core_interrupt_status_control;
   logic [7:0]              word_index;
   logic                    bank_one;
   logic                    hit_core;
   logic                    hit_pen1;
   logic                    hit_stat;
   logic                    hit_mask;
   logic                    wr_core;
   logic                    wr_pen1;
   logic                    rd_stat;
   irq_regs_pkg::bus_state_t bus_q;
   irq_regs_pkg::vec_sel_t  vec_sel;
   logic                    clr_ext;
   logic                    clr_tmr0;
   logic                    clr_clk;
   logic                    take;
   logic                    reset_vec;
   logic [3:0]              events;
   logic [3:0]              en_pend;

   // Pin-level event inputs pass two flip-flops
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ext_meta_q <= 8'h00;
         ext_sync_q <= 8'h00;
      end else if (CE) begin
         ext_meta_q <= {5'h00, TIMER_ZERO_OVF, CLK_PIN_EDGE, EXT_PIN_EDGE};
         ext_sync_q <= ext_meta_q;
      end
   end

   // Bus decode: byte address is four times the index
   assign word_index = ADDRESS[9:2];
   assign bank_one   = (BANK_SEL == `PERIPH_EN1_BANK);
   assign hit_core   = (word_index == `CORE_STATUS_INDEX);
   assign hit_pen1   = (word_index == `PERIPH_EN1_INDEX) && bank_one;
   assign hit_stat   = (word_index == `IRQ_STATUS_INDEX);
   assign hit_mask   = (word_index == `IRQ_MASK_INDEX);
   assign WAITREQUEST = (READ || WRITE) && (bus_q == irq_regs_pkg::BUS_IDLE);
   assign wr_core = WRITE && !WAITREQUEST && hit_core && BYTEENABLE[0];
   assign wr_pen1 = WRITE && !WAITREQUEST && hit_pen1 && BYTEENABLE[0];
   assign rd_stat = READ && !WAITREQUEST && hit_stat;

   // One wait state per access
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         bus_q <= irq_regs_pkg::BUS_IDLE;
      end else if (CE) begin
         if (bus_q == irq_regs_pkg::BUS_ACK) begin
            bus_q <= irq_regs_pkg::BUS_IDLE;
         end else if (READ || WRITE) begin
            bus_q <= irq_regs_pkg::BUS_ACK;
         end else begin
            bus_q <= irq_regs_pkg::BUS_IDLE;
         end
      end
   end

   // Read data registered in the wait cycle, stands at the ack edge
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         READDATA <= 32'h00000000;
      end else if (CE) begin
         if (READ && bus_q == irq_regs_pkg::BUS_IDLE) begin
            if (hit_core) begin
               READDATA <= {24'h000000, core_interrupt_status_control};
            end else if (hit_pen1) begin
               READDATA <= {24'h000000, peripheral_enable_first};
            end else if (hit_stat) begin
               READDATA <= {28'h0000000, irq_status_q};
            end else if (hit_mask) begin
               READDATA <= {28'h0000000, irq_mask_q};
            end else begin
               READDATA <= 32'h00000000;
            end
         end
      end
   end

   // Read-only summary of every peripheral flag
   assign peripheral_summary_flag = |{PERIPH_FLAGS, PERIPH_FLAGS_HI};

   assign core_interrupt_status_control = {
      peripheral_summary_flag, clock_pin_edge_flag,
      timer_zero_overflow_flag, ext_pin_edge_flag, core_en_q};

   // Flags set by condition regardless of enables
   sticky_flag u_ext (
      .clk    (REF_CLK),
      .rst_n  (NRST),
      .ce     (CE),
      .set    (ext_sync_q[0]),
      .clr    (clr_ext),
      .wr_en  (wr_core),
      .wr_val (WRITEDATA[`EXT_PIN_FLAG_BIT]),
      .flag   (ext_pin_edge_flag)
   );

   sticky_flag u_clk (
      .clk    (REF_CLK),
      .rst_n  (NRST),
      .ce     (CE),
      .set    (ext_sync_q[1]),
      .clr    (clr_clk),
      .wr_en  (wr_core),
      .wr_val (WRITEDATA[`CLK_PIN_FLAG_BIT]),
      .flag   (clock_pin_edge_flag)
   );

   sticky_flag u_tmr0 (
      .clk    (REF_CLK),
      .rst_n  (NRST),
      .ce     (CE),
      .set    (ext_sync_q[2]),
      .clr    (clr_tmr0),
      .wr_en  (wr_core),
      .wr_val (WRITEDATA[`TMR0_FLAG_BIT]),
      .flag   (timer_zero_overflow_flag)
   );

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         core_en_q <= 4'h0;
      end else if (CE && wr_core) begin
         core_en_q <= WRITEDATA[3:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         peripheral_enable_first <= `PERIPH_EN1_RESET;
      end else if (CE && wr_pen1) begin
         peripheral_enable_first <= WRITEDATA[7:0];
      end
   end

   // Per-source gating of peripheral requests
   always_comb begin
      PERIPH_REQUESTS = PERIPH_FLAGS & peripheral_enable_first;
      PERIPH_REQUESTS[`PORT_B_EN_BIT] = PERIPH_FLAGS[`PORT_B_EN_BIT] &
         peripheral_enable_first[`PORT_B_EN_BIT];
      PERIPH_REQUESTS[`TMR3_EN_BIT] = PERIPH_FLAGS[`TMR3_EN_BIT] &
         peripheral_enable_first[`TMR3_EN_BIT];
      PERIPH_REQUESTS[`TMR2_EN_BIT] = PERIPH_FLAGS[`TMR2_EN_BIT] &
         peripheral_enable_first[`TMR2_EN_BIT];
   end

   assign en_pend[0] = ext_pin_edge_flag & core_en_q[`EXT_PIN_EN_BIT];
   assign en_pend[1] = timer_zero_overflow_flag & core_en_q[`TMR0_EN_BIT];
   assign en_pend[2] = clock_pin_edge_flag & core_en_q[`CLK_PIN_EN_BIT];
   assign en_pend[3] = (|PERIPH_REQUESTS || (|PERIPH_FLAGS_HI)) &
                       core_en_q[`PERIPH_SUM_EN_BIT];

   // Flag set while its enable is cleared with interrupts on: reset vector
   assign reset_vec = wr_core && !global_interrupt_disable_q &&
      ((ext_pin_edge_flag && !WRITEDATA[`EXT_PIN_EN_BIT]) ||
       (timer_zero_overflow_flag && !WRITEDATA[`TMR0_EN_BIT]) ||
       (clock_pin_edge_flag && !WRITEDATA[`CLK_PIN_EN_BIT]) ||
       (peripheral_summary_flag && !WRITEDATA[`PERIPH_SUM_EN_BIT])) &&
      (en_pend != 4'h0);

   // Fixed priority: pin, timer zero, clock pin, peripherals
   always_comb begin
      vec_sel = irq_regs_pkg::VEC_NONE;
      if (reset_vec) begin
         vec_sel = irq_regs_pkg::VEC_RST;
      end else if (en_pend[0]) begin
         vec_sel = irq_regs_pkg::VEC_EXT;
      end else if (en_pend[1]) begin
         vec_sel = irq_regs_pkg::VEC_TMR0;
      end else if (en_pend[2]) begin
         vec_sel = irq_regs_pkg::VEC_CLKPIN;
      end else if (en_pend[3]) begin
         vec_sel = irq_regs_pkg::VEC_PERIPH;
      end
   end

   assign IRQ_REQUEST = !global_interrupt_disable_q &&
                        (vec_sel != irq_regs_pkg::VEC_NONE);
   assign take     = CE && CORE_ACK && IRQ_REQUEST;
   assign clr_ext  = take && (vec_sel == irq_regs_pkg::VEC_EXT);
   assign clr_tmr0 = take && (vec_sel == irq_regs_pkg::VEC_TMR0);
   assign clr_clk  = take && (vec_sel == irq_regs_pkg::VEC_CLKPIN);

   // Vector output registered at acceptance
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         VECTOR_ADDR <= `VEC_RESET;
         VECTOR_LOAD <= 1'b0;
         PUSH_RETURN <= 1'b0;
      end else if (CE) begin
         VECTOR_LOAD <= take;
         PUSH_RETURN <= take;
         if (take) begin
            case (vec_sel)
               irq_regs_pkg::VEC_EXT:    VECTOR_ADDR <= `VEC_EXT_PIN;
               irq_regs_pkg::VEC_TMR0:   VECTOR_ADDR <= `VEC_TMR0;
               irq_regs_pkg::VEC_CLKPIN: VECTOR_ADDR <= `VEC_CLK_PIN;
               irq_regs_pkg::VEC_PERIPH: VECTOR_ADDR <= `VEC_PERIPH;
               default:                  VECTOR_ADDR <= `VEC_RESET;
            endcase
         end
      end
   end

   // Global disable: set on take, cleared by return
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         global_interrupt_disable_q <= 1'b0;
      end else if (CE) begin
         if (take || GLOBAL_DIS_SET) begin
            global_interrupt_disable_q <= 1'b1;
         end else if (RETURN_FROM_INTERRUPT || GLOBAL_DIS_CLR) begin
            global_interrupt_disable_q <= 1'b0;
         end
      end
   end
   assign GLOBAL_INTERRUPT_DISABLE = global_interrupt_disable_q;

   // Sticky bus interrupt status; read clears, set wins
   assign events = {ext_sync_q[2], ext_sync_q[1], ext_sync_q[0],
                    peripheral_summary_flag};
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_status_q <= 4'h0;
      end else if (CE) begin
         // Clear only what the read returned; later events survive
         irq_status_q <= events |
            (irq_status_q & ~(rd_stat ? READDATA[3:0] : 4'h0));
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_mask_q <= 4'h0;
      end else if (CE && WRITE && !WAITREQUEST && hit_mask && BYTEENABLE[0]) begin
         irq_mask_q <= WRITEDATA[3:0];
      end
   end

   assign IRQ = |(irq_status_q & irq_mask_q);
endmodule

// [src/irq_regs_params.svh]
`ifndef IRQ_REGS_PARAMS_SVH
`define IRQ_REGS_PARAMS_SVH

// Data addresses (printed offsets are not all multiples of four: index)
`define CORE_STATUS_INDEX   8'h07
`define PERIPH_EN1_INDEX    8'h17
`define IRQ_STATUS_INDEX    8'h20
`define IRQ_MASK_INDEX      8'h21
`define CORE_STATUS_BANK    4'h0
`define PERIPH_EN1_BANK     4'h1

// Core status/control field positions
`define PERIPH_SUM_FLAG_BIT 7
`define CLK_PIN_FLAG_BIT    6
`define TMR0_FLAG_BIT       5
`define EXT_PIN_FLAG_BIT    4
`define PERIPH_SUM_EN_BIT   3
`define CLK_PIN_EN_BIT      2
`define TMR0_EN_BIT         1
`define EXT_PIN_EN_BIT      0

// First peripheral enable field positions
`define PORT_B_EN_BIT       7
`define TMR3_EN_BIT         6
`define TMR2_EN_BIT         5

// Reset values
`define CORE_STATUS_RESET   8'h00
`define PERIPH_EN1_RESET    8'h00
`define IRQ_MASK_RESET      8'h00

// Interrupt vectors
`define VEC_EXT_PIN         16'h0008
`define VEC_TMR0            16'h0010
`define VEC_CLK_PIN         16'h0018
`define VEC_PERIPH          16'h0020
`define VEC_RESET           16'h0000

`endif

// [src/irq_regs_pkg.sv]
package irq_regs_pkg;
   typedef enum logic [2:0] {
      VEC_NONE   = 3'h0,
      VEC_EXT    = 3'h1,
      VEC_TMR0   = 3'h3,
      VEC_CLKPIN = 3'h2,
      VEC_PERIPH = 3'h6,
      VEC_RST    = 3'h7
   } vec_sel_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ACK  = 2'h1
   } bus_state_t;
endpackage

// [src/sticky_flag.sv]
`timescale 1ns/100ps
module sticky_flag (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic set,
   input  wire logic clr,
   input  wire logic wr_en,
   input  wire logic wr_val,
   output logic      flag
);
   // Set wins over both hardware clear and software write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (ce) begin
         if (set) begin
            flag <= 1'b1;
         end else if (clr) begin
            flag <= 1'b0;
         end else if (wr_en) begin
            flag <= wr_val;
         end
      end
   end
endmodule

// [tb/irq_regs_asserts.sv]
`timescale 1ns/100ps
module irq_regs_checker (
   input wire logic        REF_CLK,
   input wire logic        NRST,
   input wire logic        READ,
   input wire logic        WRITE,
   input wire logic        WAITREQUEST,
   input wire logic [31:0] READDATA,
   input wire logic        CORE_ACK,
   input wire logic        RETURN_FROM_INTERRUPT,
   input wire logic        GLOBAL_DIS_SET,
   input wire logic        IRQ_REQUEST,
   input wire logic [15:0] VECTOR_ADDR,
   input wire logic        VECTOR_LOAD,
   input wire logic        PUSH_RETURN,
   input wire logic        GLOBAL_INTERRUPT_DISABLE,
   input wire logic [7:0]  PERIPH_FLAGS,
   input wire logic [7:0]  PERIPH_REQUESTS
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   a_bus_one_wait:
   assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
      else $error("bus answer late");
   a_readdata_holds:
   assert property (!READ |=> $stable(READDATA))
      else $error("read data moved without a read");
   a_take_vectors:
   assert property (CORE_ACK && IRQ_REQUEST |=> VECTOR_LOAD && PUSH_RETURN
                    && GLOBAL_INTERRUPT_DISABLE)
      else $error("take did not vector");
   a_vector_one_pulse:
   assert property (VECTOR_LOAD |=> !VECTOR_LOAD [*2])
      else $error("vector load too long");
   a_disable_blocks:
   assert property (GLOBAL_INTERRUPT_DISABLE |-> !IRQ_REQUEST)
      else $error("request while disabled");
   a_return_clears:
   assert property (RETURN_FROM_INTERRUPT && !CORE_ACK && !GLOBAL_DIS_SET
                    |=> !GLOBAL_INTERRUPT_DISABLE)
      else $error("return kept disable");
   a_periph_gated:
   assert property ($stable(PERIPH_FLAGS) [*2]
                    |-> (PERIPH_REQUESTS & ~PERIPH_FLAGS) == 8'h00)
      else $error("request without flag");
   a_vector_legal:
   assert property (VECTOR_LOAD |-> VECTOR_ADDR inside
                    {16'h0000, 16'h0008, 16'h0010, 16'h0018, 16'h0020})
      else $error("illegal vector");
   a_reset_quiet:
   assert property ($rose(NRST) |-> !VECTOR_LOAD && !GLOBAL_INTERRUPT_DISABLE
                    && VECTOR_ADDR == 16'h0000)
      else $error("outputs busy after reset");
   cover property (VECTOR_LOAD && VECTOR_ADDR == 16'h0008);
   cover property (VECTOR_LOAD && VECTOR_ADDR == 16'h0020);
   cover property (READ && !WAITREQUEST);
endmodule

bind interrupt_status_enable_regs irq_regs_checker u_chk (
   .REF_CLK, .NRST, .READ, .WRITE, .WAITREQUEST, .READDATA, .CORE_ACK,
   .RETURN_FROM_INTERRUPT, .GLOBAL_DIS_SET, .IRQ_REQUEST, .VECTOR_ADDR,
   .VECTOR_LOAD, .PUSH_RETURN, .GLOBAL_INTERRUPT_DISABLE, .PERIPH_FLAGS,
   .PERIPH_REQUESTS);

// [tb/core_side_model.sv]
`timescale 1ns/100ps
module core_side_model (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic slow,
   input  wire logic irq_request,
   input  wire logic vector_load,
   output logic      core_ack,
   output logic      ret
);
   logic [3:0] wait_q;
   logic [3:0] isr_q;
   // Accept a request promptly or after five cycles
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_q   <= 4'h0;
         core_ack <= 1'b0;
      end else begin
         core_ack <= 1'b0;
         if (irq_request && !core_ack) begin
            if (!slow || wait_q == 4'h5) begin
               core_ack <= 1'b1;
               wait_q   <= 4'h0;
            end else
               wait_q <= wait_q + 4'h1;
         end else
            wait_q <= 4'h0;
      end
   end
   // Short service routine, then return
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         isr_q <= 4'h0;
         ret   <= 1'b0;
      end else begin
         ret   <= (isr_q == 4'h4);
         isr_q <= vector_load ? 4'h1 : (isr_q == 4'h0 || isr_q == 4'h4)
                  ? 4'h0 : isr_q + 4'h1;
      end
   end
endmodule

// [tb/interrupt_status_enable_regs_tb_top.sv]
`timescale 1ns/100ps
module interrupt_status_enable_regs_tb_top;
   logic        REF_CLK = 1'b0;
   logic        NRST = 1'b0;
   logic        READ = 1'b0, WRITE = 1'b0, slow = 1'b0;
   logic        EXT_PIN_EDGE = 1'b0, CLK_PIN_EDGE = 1'b0;
   logic        TIMER_ZERO_OVF = 1'b0;
   logic        CE = 1'b1;
   logic [9:0]  ADDRESS = 10'h000;
   logic [31:0] WRITEDATA = 32'h0, READDATA, rd;
   logic [3:0]  BANK_SEL = 4'h0;
   logic [7:0]  PERIPH_FLAGS = 8'h00, PERIPH_FLAGS_HI = 8'h00;
   logic [7:0]  lf = 8'h62, v, f, PERIPH_REQUESTS;
   logic        WAITREQUEST, IRQ_REQUEST, VECTOR_LOAD, PUSH_RETURN, IRQ;
   logic        GLOBAL_INTERRUPT_DISABLE, CORE_ACK, RETURN_FROM_INTERRUPT;
   logic [15:0] VECTOR_ADDR;
   int          n_mismatch = 0, check_count = 0;
   always #5 REF_CLK = ~REF_CLK;
   interrupt_status_enable_regs u_dut (.REF_CLK, .NRST, .CE, .ADDRESS,
      .READ, .WRITE, .BYTEENABLE(4'hf), .WRITEDATA, .READDATA, .WAITREQUEST,
      .BANK_SEL, .EXT_PIN_EDGE, .CLK_PIN_EDGE, .TIMER_ZERO_OVF, .PERIPH_FLAGS,
      .PERIPH_FLAGS_HI, .CORE_ACK, .RETURN_FROM_INTERRUPT,
      .GLOBAL_DIS_SET(1'b0), .GLOBAL_DIS_CLR(1'b0), .IRQ_REQUEST, .VECTOR_ADDR,
      .VECTOR_LOAD, .PUSH_RETURN, .GLOBAL_INTERRUPT_DISABLE, .PERIPH_REQUESTS,
      .IRQ);
   core_side_model u_core (.clk(REF_CLK), .nrst(NRST), .slow(slow),
      .irq_request(IRQ_REQUEST), .vector_load(VECTOR_LOAD),
      .core_ack(CORE_ACK), .ret(RETURN_FROM_INTERRUPT));
   task rnd(output logic [7:0] o);
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      o = lf;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Hold the request until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge REF_CLK);
      ADDRESS <= {idx, 2'b00};
      WRITE <= w;
      READ <= !w;
      WRITEDATA <= d;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (WAITREQUEST !== 1'b0 && n < 20);
      if (n >= 20) n_mismatch++;
      rd = READDATA;
      READ <= 1'b0;
      WRITE <= 1'b0;
   endtask
   task rdchk(input logic [7:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      check(rd, e);
   endtask
   task pulse(input int i);
      @(posedge REF_CLK);
      EXT_PIN_EDGE <= (i == 0);
      TIMER_ZERO_OVF <= (i == 1);
      CLK_PIN_EDGE <= (i == 2);
      @(posedge REF_CLK);
      {EXT_PIN_EDGE, TIMER_ZERO_OVF, CLK_PIN_EDGE} <= 3'h0;
   endtask
   task wait_vec(input logic [31:0] e);
      int n;
      n = 0;
      do begin
         @(negedge REF_CLK);
         n++;
      end while (VECTOR_LOAD !== 1'b1 && n < 40);
      check({16'h0, VECTOR_ADDR}, e);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge REF_CLK);
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      repeat (16) @(posedge REF_CLK);
      NRST <= 1'b1;
      BANK_SEL <= 4'h1;
      rdchk(8'h07, 32'h0);
      rdchk(8'h17, 32'h0);
      rdchk(8'hff, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         rnd(v);
         rnd(f);
         BANK_SEL <= 4'h1;
         bus(1'b1, 8'h17, {24'h0, v});
         PERIPH_FLAGS <= f;
         PERIPH_FLAGS_HI <= v ^ f;
         rdchk(8'h17, {24'h0, v});
         @(negedge REF_CLK) check(PERIPH_REQUESTS, f & v);
         BANK_SEL <= {f[3:1], 1'b0};
         bus(1'b1, 8'h17, 32'h0);
         rdchk(8'h17, 32'h0);
         rdchk(8'h07, {24'h0, |(f | (v ^ f)), 7'h0});
      end
      PERIPH_FLAGS <= 8'h00;
      PERIPH_FLAGS_HI <= 8'h00;
      $display("test enables done");
      BANK_SEL <= 4'h1;
      bus(1'b1, 8'h17, 32'h20);
      bus(1'b1, 8'h07, 32'h0f);
      for (int i = 0; i < 3; i++) begin
         rnd(v);
         slow <= v[0];
         pulse(i);
         wait_vec(32'h8 * (i + 1));
         rdchk(8'h07, 32'h0f);
      end
      PERIPH_FLAGS <= 8'h20;
      wait_vec(32'h20);
      rdchk(8'h07, 32'h8f);
      PERIPH_FLAGS <= 8'h00;
      bus(1'b1, 8'h07, 32'h0);
      $display("test vectors done");
      bus(1'b0, 8'h20, 32'h0);
      pulse(0);
      repeat (4) @(posedge REF_CLK);
      rdchk(8'h07, 32'h10);
      @(negedge REF_CLK) check(IRQ, 1'b0);
      bus(1'b1, 8'h21, 32'h2);
      @(negedge REF_CLK) check(IRQ, 1'b1);
      rdchk(8'h20, 32'h2);
      @(negedge REF_CLK) check(IRQ, 1'b0);
      bus(1'b1, 8'h07, 32'h0);
      bus(1'b1, 8'h21, 32'h0);
      $display("test sticky done");
      // Event while frozen is not captured
      @(posedge REF_CLK);
      CE <= 1'b0;
      pulse(0);
      repeat (4) @(posedge REF_CLK);
      CE <= 1'b1;
      rdchk(8'h07, 32'h0);
      $display("test freeze done");
      report_and_stop;
   end
endmodule
